/* core/ftc_pkg.sv */
// Constants, register map and carrier types of the fast timer compare and interrupt block
// Overview of operation
// - Channel B matches only when the running counter counts onto its compare value.
// - A software write making counter equal channel B value gives no match.
// - A channel B match sets its flag after a synchronisation delay.
// - Channel D behaves like channel B: counted match only, delayed flag set.
// - A match against the top compare value clears the counter in every mode.
// - Writing a top compare value below three stores three instead.
// - Mask bits 7, 6, 5 enable compare interrupts of channels D, A, B.
// - Mask bit 2 enables the counter overflow interrupt.
// - Flag bits 7, 6, 5 hold compare flags D, A, B; bit 2 overflow.
// - A compare interrupt needs global enable, channel enable and channel flag together.
// - Compare flags clear on vector taken, or one cycle after a written one.
// - Normal and fast modes set overflow when the counter hits top and wraps.
// - Phase and frequency correct mode sets overflow when zero is clocked in.
// - Overflow flag clears like compare flags; its interrupt needs global enable, overflow enable and overflow flag.
// - Dead-time register serves all channels; high and low nibbles delay each output.
// - Each dead-time field counts zero to fifteen prescaled timer clock periods.
// - A two-bit shared temporary register carries the upper bits of 10-bit accesses.
package ftc_pkg;

   // Register byte offsets on the Avalon slave
   localparam logic [4:0] OFS_FLAGS = 5'h00;
   localparam logic [4:0] OFS_FLAG_CLEAR = 5'h04;
   localparam logic [4:0] OFS_MASK = 5'h08;
   localparam logic [4:0] OFS_CMP_B = 5'h0c;
   localparam logic [4:0] OFS_CMP_TOP = 5'h10;
   localparam logic [4:0] OFS_CMP_D = 5'h14;
   localparam logic [4:0] OFS_DEAD_TIME = 5'h18;
   localparam logic [4:0] OFS_HIGH_TEMP = 5'h1c;

   // Flag and enable bit positions (same layout in both registers)
   localparam int BIT_D = 7;
   localparam int BIT_A = 6;
   localparam int BIT_B = 5;
   localparam int BIT_OVF = 2;
   localparam logic [7:0] FLAG_BITS = 8'he4;

   // Field widths and positions
   localparam int CNT_W = 10;
   localparam int HIGH_W = 2;
   localparam int DT_W = 4;
   localparam int DT_HIGH_LSB = 4;
   localparam int DT_LOW_LSB = 0;

   // Reset values
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [9:0] RST_CMP = 10'h000;
   localparam logic [9:0] RST_CMP_TOP = 10'h0ff;
   localparam logic [7:0] RST_DEAD_TIME = 8'h00;
   localparam logic [1:0] RST_HIGH_TEMP = 2'h0;

   // Lowest value the top compare register accepts
   localparam logic [9:0] TOP_MIN = 10'h003;

   // Timing counts in mclk cycles
   localparam int SYNC_STAGES = 1;
   localparam int CLEAR_DELAY = 1;

   // Waveform generation modes, decoded by the counter core outside
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_FAST,
      MODE_PFC,
      MODE_PWM6_SINGLE,
      MODE_PWM6_DUAL
   } ftc_mode_t;

   // Counter status as seen from the counter core
   typedef struct packed {
      logic [9:0] value;   // Current counter value
      logic tick;          // Counter advanced this cycle (prescaled clock)
      logic loaded;        // Counter written by software this cycle
      logic down;          // Counting direction, 1 = down
   } ftc_cnt_t;

   // Per-flag vectors of the interrupt layout
   typedef struct packed {
      logic [7:0] request; // Masked and globally enabled requests
      logic [7:0] flags;   // Raw sticky flags
   } ftc_irq_t;

endpackage : ftc_pkg

/* core/ftc_dead_time.sv */
// Dead-time inserter for one complementary output pair
`timescale 1ns/1ps
`default_nettype none
module ftc_dead_time #(
   parameter int DT_W = 4
) (
   input wire logic mclk,              // System clock
   input wire logic rstn,              // Asynchronous reset, active low
   input wire logic ce,                // Clock enable
   input wire logic tick,              // Prescaled timer clock enable
   input wire logic waveIn,            // Raw compare waveform
   input wire logic [DT_W-1:0] dtHigh, // Delay before true output rises
   input wire logic [DT_W-1:0] dtLow,  // Delay before complement rises
   output logic outTrue,               // True output
   output logic outComp                // Complementary output
);

   if (DT_W < 1)
      $error("DT_W must be at least one");

   logic waveSeen;
   logic [DT_W-1:0] delayLeft;

   // Edge of the raw wave loads the matching delay; both outputs go low at once
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         waveSeen <= 1'b0;
         delayLeft <= '0;
         outTrue <= 1'b0;
         outComp <= 1'b0;
      end
      else if (ce)
      begin
         if (waveIn != waveSeen)
         begin
            waveSeen <= waveIn;
            delayLeft <= waveIn ? dtHigh : dtLow;
            outTrue <= 1'b0;
            outComp <= 1'b0;
         end
         else if (delayLeft != '0)
         begin
            // Count only on prescaled periods so the delay scales with the timer
            if (tick)
               delayLeft <= delayLeft - 1'b1;
         end
         else
         begin
            outTrue <= waveSeen;
            outComp <= !waveSeen;
         end
      end
   end

endmodule : ftc_dead_time
`default_nettype wire

/* core/ftc_compare_irq.sv */
// Compare registers, flags, interrupts and dead time of the fast timer
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ftc_compare_irq #(
   parameter int SYNC_STAGES = ftc_pkg::SYNC_STAGES,
   parameter int CHANNELS = 3
) (
   input wire logic mclk,                        // System clock, 10 MHz
   input wire logic rstn,                        // Asynchronous reset, active low
   input wire logic ce,                          // Clock enable, freezes all state
   input wire logic [4:0] avs_address,           // Avalon byte address
   input wire logic avs_read,                    // Avalon read
   input wire logic avs_write,                   // Avalon write
   input wire logic [3:0] avs_byteenable,        // Avalon byte enables
   input wire logic [31:0] avs_writedata,        // Avalon write data
   output logic [31:0] avs_readdata,             // Avalon read data
   output logic avs_waitrequest,                 // Avalon wait request
   input wire ftc_pkg::ftc_cnt_t counter,        // Counter status from core
   input wire ftc_pkg::ftc_mode_t mode,          // Waveform generation mode
   input wire logic matchEventA,                 // Channel A match pulse from its unit
   input wire logic globalIrqEnable,             // Global interrupt enable of the CPU
   input wire logic [7:0] vectorTaken,           // Vector taken pulses, flag layout
   input wire logic [CHANNELS-1:0] waveRaw,      // Raw waveforms to dead-time
   output logic counterClear,                    // Strobe: clear counter on top match
   output logic [9:0] compareB,                  // Channel B compare value
   output logic [9:0] compareTop,                // Top compare value
   output logic [9:0] compareD,                  // Channel D compare value
   output ftc_pkg::ftc_irq_t irqState,           // Per-flag requests and flags
   output logic irq,                             // Combined interrupt, level
   output logic [CHANNELS-1:0] compareOutTrue,   // Dead-timed true outputs
   output logic [CHANNELS-1:0] compareOutComp    // Dead-timed complement outputs
);

   if (SYNC_STAGES < 1)
      $error("SYNC_STAGES must be at least one");
   if (CHANNELS < 1)
      $error("CHANNELS must be at least one");

   // Counted arrival on a compare value; a software load never counts
   function automatic logic countedHit(input ftc_pkg::ftc_cnt_t c, input logic [9:0] cmp);
      countedHit = c.tick && !c.loaded && (c.value == cmp);
   endfunction : countedHit

   // Top compare value never stored below the minimum
   function automatic logic [9:0] clampTop(input logic [9:0] v);
      clampTop = (v < ftc_pkg::TOP_MIN) ? ftc_pkg::TOP_MIN : v;
   endfunction : clampTop

   logic ack;
   logic [7:0] flags;
   logic [7:0] mask;
   logic [7:0] deadTime;
   logic [1:0] highTemp;
   logic [7:0] clearPending;
   logic [7:0] matchPipe [SYNC_STAGES];
   logic [7:0] rawEvents;
   logic [7:0] setEvents;
   logic [7:0] next_flags;
   logic [7:0] writeOnes;
   logic busWrite;
   logic busRead;
   logic overflowEvent;
   logic [9:0] writeValue;
   logic [7:0] readByte;

   // Avalon handshake: one wait cycle, the access completes on the second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign busWrite = avs_write && ack && avs_byteenable[0];
   assign busRead = avs_read && ack;
   assign writeValue = {highTemp, avs_writedata[7:0]};

   // Acknowledge toggles so each access sees exactly one wait cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ack <= 1'b0;
      else if (ce)
         ack <= (avs_read || avs_write) && !ack;
   end

   // Read mux; unmapped and write-only offsets read as zero
   always_comb
   begin
      readByte = 8'h00;
      unique case (avs_address)
         ftc_pkg::OFS_FLAGS: readByte = flags & ftc_pkg::FLAG_BITS;
         ftc_pkg::OFS_MASK: readByte = mask & ftc_pkg::FLAG_BITS;
         ftc_pkg::OFS_CMP_B: readByte = compareB[7:0];
         ftc_pkg::OFS_CMP_TOP: readByte = compareTop[7:0];
         ftc_pkg::OFS_CMP_D: readByte = compareD[7:0];
         ftc_pkg::OFS_DEAD_TIME: readByte = deadTime;
         ftc_pkg::OFS_HIGH_TEMP: readByte = {6'h00, highTemp};
         default: readByte = 8'h00;
      endcase
   end

   // Read data captured during the wait cycle, stable at the completing edge
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         avs_readdata <= 32'h00000000;
      else if (ce && avs_read && !ack)
         avs_readdata <= {24'h000000, readByte};
   end

   // Mask register holds compare and overflow enables
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         mask <= ftc_pkg::RST_MASK;
      else if (ce && busWrite && avs_address == ftc_pkg::OFS_MASK)
         mask <= avs_writedata[7:0] & ftc_pkg::FLAG_BITS;
   end

   // Dead-time value, shared by every channel
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         deadTime <= ftc_pkg::RST_DEAD_TIME;
      else if (ce && busWrite && avs_address == ftc_pkg::OFS_DEAD_TIME)
         deadTime <= avs_writedata[7:0];
   end

   // Shared high bits: written directly, or loaded when a compare low byte is read
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         highTemp <= ftc_pkg::RST_HIGH_TEMP;
      else if (ce)
      begin
         if (busWrite && avs_address == ftc_pkg::OFS_HIGH_TEMP)
            highTemp <= avs_writedata[1:0];
         else if (busRead)
         begin
            unique case (avs_address)
               ftc_pkg::OFS_CMP_B: highTemp <= compareB[9:8];
               ftc_pkg::OFS_CMP_TOP: highTemp <= compareTop[9:8];
               ftc_pkg::OFS_CMP_D: highTemp <= compareD[9:8];
               default: highTemp <= highTemp;
            endcase
         end
      end
   end

   // Compare B, written as a 10-bit value with the shared high bits
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         compareB <= ftc_pkg::RST_CMP;
      else if (ce && busWrite && avs_address == ftc_pkg::OFS_CMP_B)
         compareB <= writeValue;
   end

   // Compare D, same scheme as B
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         compareD <= ftc_pkg::RST_CMP;
      else if (ce && busWrite && avs_address == ftc_pkg::OFS_CMP_D)
         compareD <= writeValue;
   end

   // Top value is clamped so the counter period never collapses
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         compareTop <= ftc_pkg::RST_CMP_TOP;
      else if (ce && busWrite && avs_address == ftc_pkg::OFS_CMP_TOP)
         compareTop <= clampTop(writeValue);
   end

   // Top match restarts the counter the same way in every mode
   assign counterClear = countedHit(counter, compareTop);

   // Overflow point depends on the mode: top wrap for single slope, zero for dual
   always_comb
   begin
      overflowEvent = 1'b0;
      unique case (mode)
         ftc_pkg::MODE_NORMAL,
         ftc_pkg::MODE_FAST,
         ftc_pkg::MODE_PWM6_SINGLE: overflowEvent = counterClear;
         ftc_pkg::MODE_PFC,
         ftc_pkg::MODE_PWM6_DUAL: overflowEvent = counter.tick && !counter.loaded
            && counter.down && (counter.value == 10'h000);
         default: overflowEvent = 1'b0;
      endcase
   end

   // Compare events before synchronisation, in flag layout
   always_comb
   begin
      rawEvents = 8'h00;
      rawEvents[ftc_pkg::BIT_B] = countedHit(counter, compareB);
      rawEvents[ftc_pkg::BIT_D] = countedHit(counter, compareD);
      rawEvents[ftc_pkg::BIT_A] = matchEventA;
   end

   // Compare events pass a synchronisation pipeline before reaching the flags
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < SYNC_STAGES; i++)
            matchPipe[i] <= 8'h00;
      end
      else if (ce)
      begin
         matchPipe[0] <= rawEvents;
         for (int i = 1; i < SYNC_STAGES; i++)
            matchPipe[i] <= matchPipe[i-1];
      end
   end

   // Overflow is not delayed: it lands on the edge of the wrap itself
   always_comb
   begin
      setEvents = matchPipe[SYNC_STAGES-1];
      setEvents[ftc_pkg::BIT_OVF] = overflowEvent;
   end

   // Ones written to the flag or clear register, applied one cycle later
   assign writeOnes = (busWrite && (avs_address == ftc_pkg::OFS_FLAGS || avs_address == ftc_pkg::OFS_FLAG_CLEAR))
      ? (avs_writedata[7:0] & ftc_pkg::FLAG_BITS) : 8'h00;

   // Delay stage of a software clear
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         clearPending <= 8'h00;
      else if (ce)
         clearPending <= writeOnes;
   end

   // Sticky flags: vector taken or delayed write clears, a new event always wins
   always_comb
   begin
      next_flags = flags & ~clearPending & ~vectorTaken;
      next_flags = (next_flags | setEvents) & ftc_pkg::FLAG_BITS;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         flags <= ftc_pkg::RST_FLAGS;
      else if (ce)
         flags <= next_flags;
   end

   // Requests stay up while flag, enable and global enable all hold
   assign irqState.flags = flags;
   assign irqState.request = globalIrqEnable ? (flags & mask) : 8'h00;
   assign irq = |irqState.request;

   // One dead-time inserter per channel, all fed by the same register
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : gen_dead
      ftc_dead_time #(
         .DT_W(ftc_pkg::DT_W)
      ) u_dead (
         .mclk(mclk),
         .rstn(rstn),
         .ce(ce),
         .tick(counter.tick),
         .waveIn(waveRaw[ch]),
         .dtHigh(deadTime[ftc_pkg::DT_HIGH_LSB +: ftc_pkg::DT_W]),
         .dtLow(deadTime[ftc_pkg::DT_LOW_LSB +: ftc_pkg::DT_W]),
         .outTrue(compareOutTrue[ch]),
         .outComp(compareOutComp[ch])
      );
   end

endmodule : ftc_compare_irq
`default_nettype wire

/* testbench/ftc_compare_irq_chk.sv */
// Checker for the fast timer compare and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ftc_compare_irq_chk #(
   parameter int SYNC_STAGES = ftc_pkg::SYNC_STAGES
) (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset
   input wire logic ce, // Run
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic avs_waitrequest, // Wait
   input wire ftc_pkg::ftc_cnt_t counter, // Counter
   input wire ftc_pkg::ftc_mode_t mode, // Mode
   input wire logic globalIrqEnable, // Global
   input wire logic [7:0] vectorTaken, // Vectors
   input wire logic counterClear, // Clear
   input wire logic [9:0] compareB, // B
   input wire logic [9:0] compareTop, // Top
   input wire logic [9:0] compareD, // D
   input wire ftc_pkg::ftc_irq_t irqState, // Flags
   input wire logic irq // Irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic counted, matchB, matchD, ovfEvt, dual;
   // Loaded cycles never count as matches
   assign counted = counter.tick && !counter.loaded;
   assign matchB = counted && counter.value == compareB;
   assign matchD = counted && counter.value == compareD;
   assign dual = mode == ftc_pkg::MODE_PFC || mode == ftc_pkg::MODE_PWM6_DUAL;
   assign ovfEvt = counted && (dual ? counter.down && counter.value == 10'h000 : counter.value == compareTop);
   sequence s_hitB;
      ce && matchB ##1 ce;
   endsequence
   sequence s_hitD;
      ce && matchD ##1 ce;
   endsequence
   property p_waitOne;
      ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_waitOne: assert property (p_waitOne) else $error("wait cycle count wrong");
   property p_flagB;
      s_hitB |=> irqState.flags[ftc_pkg::BIT_B];
   endproperty
   a_flagB: assert property (p_flagB) else $error("B flag not set");
   property p_strayB;
      $rose(irqState.flags[ftc_pkg::BIT_B]) |-> $past(matchB, 2);
   endproperty
   a_strayB: assert property (p_strayB) else $error("B flag without match");
   property p_flagD;
      s_hitD |=> irqState.flags[ftc_pkg::BIT_D];
   endproperty
   a_flagD: assert property (p_flagD) else $error("D flag not set");
   property p_clear;
      counted && counter.value == compareTop |-> counterClear;
   endproperty
   a_clear: assert property (p_clear) else $error("top match no clear");
   property p_topMin;
      compareTop >= 10'h003;
   endproperty
   a_topMin: assert property (p_topMin) else $error("top below three");
   property p_ovf;
      ce && ovfEvt |=> irqState.flags[ftc_pkg::BIT_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not set");
   property p_vecClr;
      ce && vectorTaken[ftc_pkg::BIT_OVF] && !ovfEvt |=> !irqState.flags[ftc_pkg::BIT_OVF];
   endproperty
   a_vecClr: assert property (p_vecClr) else $error("vector clear missed");
   property p_req;
      irqState.request != 8'h00 |-> globalIrqEnable && (irqState.request & ~irqState.flags) == 8'h00;
   endproperty
   a_req: assert property (p_req) else $error("request without cause");
   property p_irq;
      irq == (|irqState.request);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not request or");
endmodule : ftc_compare_irq_chk
bind ftc_compare_irq ftc_compare_irq_chk #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.mclk(mclk), .rstn(rstn), .ce(ce),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .counter(counter), .mode(mode),
   .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken), .counterClear(counterClear), .compareB(compareB),
   .compareTop(compareTop), .compareD(compareD), .irqState(irqState), .irq(irq));
`default_nettype wire

/* testbench/ftc_compare_irq_test.sv */
// Self-checking bench for the fast timer compare and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ftc_compare_irq_test;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] busAddr = 5'h00;
   logic busRd = 1'b0;
   logic busWr = 1'b0;
   logic [31:0] busWdata = 32'h0;
   logic [31:0] busRdata;
   logic busWait;
   ftc_pkg::ftc_cnt_t counter = '0;
   ftc_pkg::ftc_mode_t mode = ftc_pkg::MODE_NORMAL;
   logic globalIrqEnable = 1'b0;
   logic [7:0] vectorTaken = 8'h00;
   logic matchA = 1'b0;
   logic [2:0] waveRaw = 3'h0;
   logic [2:0] compareOutTrue, compareOutComp;
   logic counterClear, irq, clr;
   logic [9:0] compareB, compareTop, compareD;
   ftc_pkg::ftc_irq_t irqState;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   ftc_compare_irq dut (.mclk(mclk), .rstn(rstn), .ce(1'b1), .avs_address(busAddr), .avs_read(busRd),
      .avs_write(busWr), .avs_byteenable(4'h1), .avs_writedata(busWdata), .avs_readdata(busRdata),
      .avs_waitrequest(busWait), .counter(counter), .mode(mode), .matchEventA(matchA),
      .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken), .waveRaw(waveRaw), .counterClear(counterClear),
      .compareB(compareB), .compareTop(compareTop), .compareD(compareD), .irqState(irqState), .irq(irq),
      .compareOutTrue(compareOutTrue), .compareOutComp(compareOutComp));
   // 10 MHz clock
   initial forever #50 mclk = ~mclk;
   // Hang guard, far above the roughly 140 cycles the tests need
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         n_errors = n_errors + 1;
         final_report();
      end
   end
   task automatic final_report;
      $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One Avalon transfer; held until the rising edge that sees waitrequest low, a hang ends in the timeout
   task automatic bus(input logic wrt, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge mclk);
      busAddr <= a;
      busWr <= wrt;
      busRd <= !wrt;
      busWdata <= {24'h0, d};
      @(posedge mclk);
      while (busWait !== 1'b0)
         @(posedge mclk);
      q = busRdata;
      busWr <= 1'b0;
      busRd <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(what, q, exp);
   endtask : rdc
   // One counter tick; counterClear is caught mid-cycle
   task automatic evt(input logic [9:0] v, input logic ld, input logic dn, input logic [7:0] vt);
      @(posedge mclk);
      counter <= {v, 1'b1, ld, dn};
      vectorTaken <= vt;
      @(negedge mclk);
      clr = counterClear;
      @(posedge mclk);
      counter <= {v, 2'b00, dn};
      vectorTaken <= 8'h00;
   endtask : evt
   task automatic t_regs;
      rdc(ftc_pkg::OFS_MASK, 32'h0, "mask reset");
      rdc(ftc_pkg::OFS_CMP_TOP, 32'hff, "top reset");
      wr(ftc_pkg::OFS_MASK, 8'hff);
      rdc(ftc_pkg::OFS_MASK, 32'he4, "mask bits");
      wr(ftc_pkg::OFS_HIGH_TEMP, 8'h01);
      wr(ftc_pkg::OFS_CMP_B, 8'h23);
      @(negedge mclk);
      chk("cmp b", 32'(compareB), 32'h123);
      wr(ftc_pkg::OFS_HIGH_TEMP, 8'h00);
      wr(ftc_pkg::OFS_CMP_TOP, 8'h01);
      @(negedge mclk);
      chk("top clamp", 32'(compareTop), 32'h3);
      wr(ftc_pkg::OFS_CMP_D, 8'hd0);
      rdc(5'h02, 32'h0, "unmapped");
      $display("test regs done");
   endtask : t_regs
   task automatic t_match;
      logic [9:0] v;
      int b;
      for (int i = 0; i < 2; i++)
      begin
         v = (i == 0) ? 10'h123 : 10'h0d0;
         b = (i == 0) ? 5 : 7;
         evt(v, 1'b1, 1'b0, 8'h00);
         repeat (3) @(negedge mclk);
         chk("loaded match", 32'(irqState.flags[b]), 32'h0);
         evt(v, 1'b0, 1'b0, 8'h00);
         @(negedge mclk);
         chk("early flag", 32'(irqState.flags[b]), 32'h0);
         @(negedge mclk);
         chk("flag set", 32'(irqState.flags[b]), 32'h1);
      end
      // Channel A pulse from its own unit passes the same delay
      @(posedge mclk);
      matchA <= 1'b1;
      @(posedge mclk);
      matchA <= 1'b0;
      repeat (2) @(negedge mclk);
      chk("flag a", 32'(irqState.flags[6]), 32'h1);
      $display("test match done");
   endtask : t_match
   task automatic t_irq;
      @(negedge mclk);
      chk("irq global off", 32'(irq), 32'h0);
      @(posedge mclk);
      globalIrqEnable <= 1'b1;
      @(negedge mclk);
      chk("irq on", 32'(irq), 32'h1);
      rdc(ftc_pkg::OFS_FLAGS, 32'he0, "flag layout");
      wr(ftc_pkg::OFS_FLAGS, 8'h60);
      @(negedge mclk);
      chk("w1c delay", 32'(irqState.flags[5]), 32'h1);
      @(negedge mclk);
      chk("w1c done", 32'(irqState.flags[5]), 32'h0);
      wr(ftc_pkg::OFS_MASK, 8'h64);
      @(negedge mclk);
      chk("irq masked", 32'(irq), 32'h0);
      @(posedge mclk);
      vectorTaken <= 8'h80;
      @(posedge mclk);
      vectorTaken <= 8'h00;
      @(negedge mclk);
      chk("vector clear", 32'(irqState.flags), 32'h0);
      $display("test irq done");
   endtask : t_irq
   task automatic t_ovf;
      logic dual;
      for (int m = 0; m < 5; m++)
      begin
         @(posedge mclk);
         mode <= ftc_pkg::ftc_mode_t'(m);
         dual = (m == 2 || m == 4);
         evt(10'h003, 1'b0, 1'b1, 8'h00);
         chk("top clear", 32'(clr), 32'h1);
         if (dual)
            evt(10'h000, 1'b0, 1'b1, 8'h00);
         @(negedge mclk);
         chk("overflow", 32'(irqState.flags[2]), 32'h1);
         chk("ovf irq", 32'(irq), 32'h1);
         wr(ftc_pkg::OFS_FLAG_CLEAR, 8'h04);
         repeat (2) @(negedge mclk);
         chk("ovf w1c", 32'(irqState.flags[2]), 32'h0);
      end
      @(posedge mclk);
      mode <= ftc_pkg::MODE_NORMAL;
      evt(10'h003, 1'b0, 1'b0, 8'h04);
      @(negedge mclk);
      chk("set wins", 32'(irqState.flags[2]), 32'h1);
      $display("test overflow done");
   endtask : t_ovf
   // Dead band: rising edge waits two ticking periods, falling edge one
   task automatic t_dead;
      wr(ftc_pkg::OFS_DEAD_TIME, 8'h21);
      rdc(ftc_pkg::OFS_DEAD_TIME, 32'h21, "dead time reg");
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk);
         waveRaw <= (e == 0) ? 3'h7 : 3'h0;
         counter <= {10'h200, 3'b100};
         repeat (4 - e) @(negedge mclk);
         chk("dead band", 32'({compareOutTrue, compareOutComp}), 32'h0);
         @(negedge mclk);
         chk("after dead", 32'({compareOutTrue, compareOutComp}), (e == 0) ? 32'h38 : 32'h07);
      end
      @(posedge mclk);
      counter <= '0;
      $display("test dead time done");
   endtask : t_dead
   initial
   begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      t_regs();
      t_match();
      t_irq();
      t_ovf();
      t_dead();
      final_report();
   end
endmodule : ftc_compare_irq_test
`default_nettype wire
